// file: design/amc_consts.svh
// Register offsets, field positions, codes and timing counts for mode control
`ifndef AMC_CONSTS_SVH
`define AMC_CONSTS_SVH
`define AMC_ADDR_INIT_KEY      8'h0f
`define AMC_ADDR_MODE_CTRL     8'h10
`define AMC_ADDR_BURST_COUNT   8'h29
`define AMC_ADDR_STATUS        8'h08
`define AMC_KEY_VALUE          8'h42
`define AMC_KEY_RD_STARTUP     8'h45
`define AMC_KEY_RD_READY       8'h40
`define AMC_KEY_RD_DONE        8'h43
`define AMC_MODE_CTRL_RESET    8'h00
`define AMC_BURST_COUNT_RESET  8'h01
`define AMC_BURST_CONTINUOUS   8'hff
`define AMC_BIT_X_PD           4
`define AMC_BIT_Y_PD           5
`define AMC_BIT_Z_PD           6
`define AMC_BIT_ONESHOT        7
`define AMC_HB_TRANSITIONS     3
`define AMC_STARTUP_CYCLES     16
`define AMC_LAG_MIN_MS         2
`define AMC_LAG_MAX_MS         10
`define AMC_CLK_KHZ            125000
`define AMC_LAG_CYCLES         (`AMC_LAG_MIN_MS * `AMC_CLK_KHZ)
`endif

// file: design/amc_pkg.sv
// Types shared by the mode control block
package amc_pkg;
    typedef enum logic [2:0] {
        AMC_SLEEP      = 3'h0,
        AMC_STANDBY    = 3'h1,
        AMC_WATCH      = 3'h2,
        AMC_RSV3       = 3'h3,
        AMC_RSV4       = 3'h4,
        AMC_CONTINUOUS = 3'h5,
        AMC_COMBINED   = 3'h6,
        AMC_BURST      = 3'h7
    } amc_mode_t;
    typedef enum logic [3:0] {
        AMC_ST_STARTUP = 4'b0001,
        AMC_ST_READY   = 4'b0010,
        AMC_ST_KEYED   = 4'b0100,
        AMC_ST_SPARE   = 4'b1000
    } amc_key_state_t;
endpackage : amc_pkg

// file: design/amc_sync_pulse.sv
// Two-stage synchroniser with rising-edge pulse
`timescale 1ns/100ps
`default_nettype none
module amc_sync_pulse (
    input  wire logic clk,
    input  wire logic rstn,
    input  wire logic din,
    output logic      rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    assign rise = s2_q & ~s3_q;
endmodule : amc_sync_pulse
`default_nettype wire

// file: design/amc_mode_ctrl.sv
// Operating-mode control for a three-axis motion sensor
// What this block does
// - Key reads 0x45 in start-up, 0x40 after
// - After key written, key reads 0x43
// - Mode change applies within three heartbeat ticks
// - Hardware may change mode selector itself
// - Status mode read-back lags a fixed LAG_CYCLES clocks, 2 ms by default
// - 000 sleep, 001 standby, 011/100 reserved
// - 010 watch, activity switches to continuous
// - 101 continuous sampling, watch inactive
// - 110 watch, sampling and buffer together
// - 111 counted burst, then back to sleep
// - Bits 4-6 power down X, Y, Z
// - Bit 7 starts one-shot burst; 255 continuous
// - Burst count comes from register 0x29
// - One-shot burst only starts from standby; selector code 111 starts burst from any mode
// - One-shot burst completes back to standby
// - External trigger: interrupt pin samples, selector burst
`include "amc_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module amc_mode_ctrl
    import amc_pkg::*;
#(
    parameter int STARTUP_CYCLES = `AMC_STARTUP_CYCLES,
    parameter int LAG_CYCLES     = `AMC_LAG_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic       heartbeat,
    input  wire logic       activity_det,
    input  wire logic       sample_done,
    input  wire logic       external_sample_trigger_enable,
    input  wire logic       interrupt_pin_in,
    output logic [2:0]      mode_selector,
    output logic [2:0]      active_mode,
    output logic [2:0]      status_mode,
    output logic            clocks_on,
    output logic            watch_on,
    output logic            sampling_on,
    output logic            buffer_on,
    output logic            sample_strobe,
    output logic            x_powerdown,
    output logic            y_powerdown,
    output logic            z_powerdown
);
    amc_key_state_t key_q;
    logic [$clog2(STARTUP_CYCLES+1)-1:0] su_cnt_q;
    logic [7:0]  mode_ctrl_q;
    logic [7:0]  burst_sample_count_q;
    logic [7:0]  burst_left_q;
    logic        oneshot_q;
    logic [2:0]  active_q;
    logic [1:0]  hb_cnt_q;
    logic [2:0]  status_q;
    logic [31:0] lag_cnt_q;
    logic [7:0]  rdata_q;
    logic [2:0]  pd_q;
    logic        strobe_q;
    logic        ext_q;

    wire hb_tick;
    wire counted_burst_mode_rise;
    amc_sync_pulse u_hb (
        .clk  (clk),
        .rstn (rstn),
        .din  (heartbeat),
        .rise (hb_tick)
    );
    amc_sync_pulse u_counted_burst_mode (
        .clk  (clk),
        .rstn (rstn),
        .din  (interrupt_pin_in),
        .rise (counted_burst_mode_rise)
    );

    // Register decode
    wire wr_key   = reg_wr & (reg_addr == `AMC_ADDR_INIT_KEY);
    wire wr_mode  = reg_wr & (reg_addr == `AMC_ADDR_MODE_CTRL);
    wire wr_count = reg_wr & (reg_addr == `AMC_ADDR_BURST_COUNT);
    wire key_ok   = wr_key & (reg_wdata == `AMC_KEY_VALUE);
    wire [2:0] sel     = mode_ctrl_q[2:0];
    wire [2:0] wr_sel  = reg_wdata[2:0];
    wire       wr_shot = wr_mode & reg_wdata[`AMC_BIT_ONESHOT];

    // Burst start only from standby, one-shot command path
    wire shot_go = wr_shot & (active_q == AMC_STANDBY) & (sel == AMC_STANDBY);
    wire continuous_burst = burst_sample_count_q == `AMC_BURST_CONTINUOUS;
    wire in_burst  = active_q == AMC_BURST;
    wire burst_end = in_burst & sample_done & ~continuous_burst & (burst_left_q == 8'h01);
    wire act_hit   = (active_q == AMC_WATCH) & activity_det;

    // Hardware-driven selector update
    logic [2:0] sel_hw;
    always_comb begin
        sel_hw = sel;
        if (act_hit) begin
            sel_hw = AMC_CONTINUOUS;
        end else if (burst_end) begin
            sel_hw = oneshot_q ? AMC_STANDBY : AMC_SLEEP;
        end
    end

    wire sel_reserved = (wr_sel == AMC_RSV3) | (wr_sel == AMC_RSV4);
    wire [2:0] sel_next = shot_go ? AMC_BURST :
                          (wr_mode & ~sel_reserved & ~wr_shot) ? wr_sel : sel_hw;
    wire hb_apply = hb_tick & (hb_cnt_q == 2'(`AMC_HB_TRANSITIONS - 1));
    wire pending  = sel != active_q;

    // Init key sequence
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            key_q    <= AMC_ST_STARTUP;
            su_cnt_q <= '0;
        end else begin
            unique case (key_q)
                AMC_ST_STARTUP: begin
                    su_cnt_q <= su_cnt_q + 1'b1;
                    if (su_cnt_q == ($bits(su_cnt_q))'(STARTUP_CYCLES - 1)) begin
                        key_q <= AMC_ST_READY;
                    end
                end
                AMC_ST_READY: begin
                    if (key_ok) begin
                        key_q <= AMC_ST_KEYED;
                    end
                end
                AMC_ST_KEYED: key_q <= AMC_ST_KEYED;
                default:      key_q <= AMC_ST_STARTUP;
            endcase
        end
    end

    // Control registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode_ctrl_q          <= `AMC_MODE_CTRL_RESET;
            burst_sample_count_q <= `AMC_BURST_COUNT_RESET;
            oneshot_q            <= 1'b0;
        end else begin
            if (wr_mode) begin
                mode_ctrl_q[6:4] <= reg_wdata[6:4];
            end
            mode_ctrl_q[2:0] <= sel_next;
            if (wr_count) begin
                burst_sample_count_q <= reg_wdata;
            end
            if (shot_go) begin
                oneshot_q <= 1'b1;
            end else if (wr_mode & ~wr_shot) begin
                oneshot_q <= 1'b0;
            end
        end
    end

    // Heartbeat-paced mode apply, on the third tick
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            active_q <= AMC_SLEEP;
            hb_cnt_q <= 2'h0;
        end else if (act_hit || burst_end) begin
            active_q <= sel_hw;
            hb_cnt_q <= 2'h0;
        end else if (!pending) begin
            hb_cnt_q <= 2'h0;
        end else if (hb_apply) begin
            active_q <= sel;
            hb_cnt_q <= 2'h0;
        end else if (hb_tick) begin
            hb_cnt_q <= hb_cnt_q + 2'h1;
        end
    end

    // Burst sample counter and sample trigger
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            burst_left_q <= 8'h00;
            strobe_q     <= 1'b0;
            ext_q        <= 1'b0;
        end else begin
            ext_q <= external_sample_trigger_enable;
            if (!in_burst) begin
                burst_left_q <= burst_sample_count_q;
            end else if (sample_done && burst_left_q != 8'h01) begin
                burst_left_q <= burst_left_q - 8'h01;
            end
            strobe_q <= in_burst & ext_q & ~oneshot_q & counted_burst_mode_rise;
        end
    end

    // Status read-back lag
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_q  <= AMC_SLEEP;
            lag_cnt_q <= 32'h0;
        end else if (status_q == active_q) begin
            lag_cnt_q <= 32'h0;
        end else if (lag_cnt_q == 32'(LAG_CYCLES - 1)) begin
            status_q  <= active_q;
            lag_cnt_q <= 32'h0;
        end else begin
            lag_cnt_q <= lag_cnt_q + 32'h1;
        end
    end

    // Read mux
    wire [7:0] key_rd = (key_q == AMC_ST_KEYED) ? `AMC_KEY_RD_DONE :
                        (key_q == AMC_ST_READY) ? `AMC_KEY_RD_READY :
                        `AMC_KEY_RD_STARTUP;
    wire [7:0] rd_mux = (reg_addr == `AMC_ADDR_INIT_KEY)    ? key_rd :
                        (reg_addr == `AMC_ADDR_STATUS)      ? {5'h00, status_q} :
                        (reg_addr == `AMC_ADDR_BURST_COUNT) ? burst_sample_count_q :
                        8'h00;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
            pd_q    <= 3'h0;
        end else begin
            if (reg_rd) begin
                rdata_q <= rd_mux;
            end
            if (wr_mode) begin
                pd_q <= {reg_wdata[`AMC_BIT_Z_PD], reg_wdata[`AMC_BIT_Y_PD],
                         reg_wdata[`AMC_BIT_X_PD]};
            end
        end
    end

    // Function enables per active mode
    logic [3:0] fn_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fn_q <= 4'h0;
        end else begin
            unique case (active_q)
                AMC_SLEEP:      fn_q <= 4'b0000;
                AMC_STANDBY:    fn_q <= 4'b0001;
                AMC_WATCH:      fn_q <= 4'b0011;
                AMC_CONTINUOUS: fn_q <= 4'b0101;
                AMC_COMBINED:   fn_q <= 4'b1111;
                AMC_BURST:      fn_q <= 4'b0101;
                default:        fn_q <= 4'b0001;
            endcase
        end
    end

    assign reg_rdata     = rdata_q;
    assign mode_selector = mode_ctrl_q[2:0];
    assign active_mode   = active_q;
    assign status_mode   = status_q;
    assign clocks_on     = fn_q[0];
    assign watch_on      = fn_q[1];
    assign sampling_on   = fn_q[2];
    assign buffer_on     = fn_q[3];
    assign sample_strobe = strobe_q;
    assign x_powerdown   = pd_q[0];
    assign y_powerdown   = pd_q[1];
    assign z_powerdown   = pd_q[2];
endmodule : amc_mode_ctrl
`default_nettype wire

// file: tb/amc_mode_ctrl_props.sv
// Port assertions for the mode control block
`timescale 1ns/100ps
`default_nettype none
module amc_mode_ctrl_props (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       activity_det,
    input wire logic [2:0] mode_selector,
    input wire logic [2:0] active_mode,
    input wire logic       clocks_on,
    input wire logic       watch_on,
    input wire logic       sampling_on,
    input wire logic       buffer_on,
    input wire logic       x_powerdown,
    input wire logic       y_powerdown,
    input wire logic       z_powerdown
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire mc_wr = reg_wr && reg_addr == 8'h10;
    a_axis_pd_follow : assert property (
        mc_wr |=> {z_powerdown, y_powerdown, x_powerdown} == $past(reg_wdata[6:4]))
        else $error("axis powerdown differs from written bits");
    a_reserved_code_drop : assert property (
        mc_wr && reg_wdata[2:0] inside {3'h3, 3'h4} |=> !(mode_selector inside {3'h3, 3'h4}))
        else $error("reserved selector code stored");
    a_sleep_no_clock : assert property (
        active_mode == 3'h0 |=> !clocks_on && !sampling_on)
        else $error("sleep mode has clocks or sampling");
    a_standby_idle : assert property (
        active_mode == 3'h1 |=> clocks_on && !sampling_on && !watch_on)
        else $error("standby enables wrong");
    a_watch_only : assert property (
        active_mode == 3'h2 |=> watch_on && !sampling_on && !buffer_on)
        else $error("watch mode enables wrong");
    a_activity_wakes : assert property (
        active_mode == 3'h2 && activity_det |-> ##[1:4] active_mode == 3'h5)
        else $error("activity did not switch to continuous");
    a_cont_sampling : assert property (
        active_mode == 3'h5 |=> sampling_on && !watch_on)
        else $error("continuous mode enables wrong");
    a_combined_all : assert property (
        active_mode == 3'h6 |=> watch_on && sampling_on && buffer_on)
        else $error("combined mode enables wrong");
    a_burst_refused : assert property (
        mc_wr && reg_wdata[7] && reg_wdata[2:0] != 3'h7
        && !(mode_selector == 3'h1 && active_mode == 3'h1) |=> mode_selector != 3'h7)
        else $error("burst started outside standby");
endmodule : amc_mode_ctrl_props
bind amc_mode_ctrl amc_mode_ctrl_props u_props (.clk(clk), .rstn(rstn), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .activity_det(activity_det),
    .mode_selector(mode_selector), .active_mode(active_mode), .clocks_on(clocks_on),
    .watch_on(watch_on), .sampling_on(sampling_on), .buffer_on(buffer_on),
    .x_powerdown(x_powerdown), .y_powerdown(y_powerdown), .z_powerdown(z_powerdown));
`default_nettype wire

// file: tb/amc_host_model.sv
// Host controller model driving the register strobes
`timescale 1ns/100ps
`default_nettype none
module amc_host_model (
    input wire logic       clk,
    output var logic       reg_wr,
    output var logic       reg_rd,
    output var logic [7:0] reg_addr,
    output var logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // Caller writes the key first and never bit 3
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask : rd
endmodule : amc_host_model
`default_nettype wire

// file: tb/accel_mode_control_tb_top.sv
// Self-checking bench for the mode control block
`timescale 1ns/100ps
`default_nettype none
module accel_mode_control_tb_top;
    logic clk = 1'b0, rstn = 1'b0, hb = 1'b0, act = 1'b0, sdone = 1'b0;
    logic reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;
    logic [2:0] msel, amode, smode;
    logic xpd, ypd, zpd;
    logic ext = 1'b0, ipin = 1'b0;
    logic strobe, son;
    int bad_count = 0, checks_done = 0;
    always #4 clk = ~clk;
    amc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    amc_mode_ctrl #(.STARTUP_CYCLES(16), .LAG_CYCLES(20)) DUT (.clk(clk), .rstn(rstn),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .heartbeat(hb), .activity_det(act), .sample_done(sdone),
        .external_sample_trigger_enable(ext), .interrupt_pin_in(ipin),
        .mode_selector(msel), .active_mode(amode), .status_mode(smode), .clocks_on(),
        .watch_on(), .sampling_on(son), .buffer_on(), .sample_strobe(strobe),
        .x_powerdown(xpd), .y_powerdown(ypd), .z_powerdown(zpd));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    task automatic tick(input int n);
        repeat (n) begin
            repeat (3) @(negedge clk);
            hb = 1'b1;
            repeat (3) @(negedge clk);
            hb = 1'b0;
        end
        repeat (4) @(negedge clk);
    endtask : tick
    task automatic key_sequence;
        host.rd(8'h0f, rv);
        check(rv, 8'h45);
        repeat (20) @(negedge clk);
        host.rd(8'h0f, rv);
        check(rv, 8'h40);
        host.wr(8'h0f, 8'h41);
        host.rd(8'h0f, rv);
        check(rv, 8'h40);
        host.wr(8'h0f, 8'h42);
        host.rd(8'h0f, rv);
        check(rv, 8'h43);
    endtask : key_sequence
    task automatic mode_table;
        logic [7:0] v [4] = '{8'h75, 8'h06, 8'h00, 8'h01};
        logic [2:0] prev = 3'h0;
        foreach (v[i]) begin
            host.wr(8'h10, v[i]);
            check({1'b0, zpd, ypd, xpd, 4'h0}, v[i] & 8'h70);
            tick(2);
            check({5'h0, amode == v[i][2:0]}, 8'h00);
            tick(1);
            check({5'h0, amode}, {5'h0, v[i][2:0]});
            check({5'h0, smode}, {5'h0, prev});
            prev = v[i][2:0];
            repeat (30) @(negedge clk);
            host.rd(8'h08, rv);
            check(rv & 8'h07, v[i] & 8'h07);
        end
        host.wr(8'h10, 8'h13);
        check({5'h0, msel}, 8'h01);
    endtask : mode_table
    task automatic watch_to_continuous;
        host.wr(8'h10, 8'h02);
        tick(3);
        act = 1'b1;
        repeat (6) @(negedge clk);
        act = 1'b0;
        check({5'h0, amode}, 8'h05);
        check({5'h0, msel}, 8'h05);
    endtask : watch_to_continuous
    task automatic oneshot_burst;
        host.wr(8'h10, 8'h85);
        check({5'h0, msel}, 8'h05);
        host.wr(8'h10, 8'h01);
        tick(3);
        host.wr(8'h29, 8'h03);
        host.wr(8'h10, 8'h81);
        check({5'h0, msel}, 8'h07);
        tick(3);
        check({5'h0, amode}, 8'h07);
        for (int i = 0; i < 3; i++) begin
            check({5'h0, msel}, 8'h07);
            @(negedge clk);
            sdone = 1'b1;
            @(negedge clk);
            sdone = 1'b0;
        end
        check({2'h0, msel, amode}, 8'h09);
    endtask : oneshot_burst
    task automatic ext_trigger_burst;
        int n;
        n = 0;
        host.wr(8'h29, 8'h02);
        host.wr(8'h10, 8'h07);
        check({5'h0, msel}, 8'h07);
        tick(3);
        check({5'h0, amode}, 8'h07);
        check({7'h0, son}, 8'h01);
        ext = 1'b1;
        repeat (2) @(negedge clk);
        ipin = 1'b1;
        repeat (6) begin
            @(negedge clk);
            n += strobe;
        end
        ipin = 1'b0;
        check(8'(n), 8'h01);
        repeat (2) begin
            @(negedge clk);
            sdone = 1'b1;
            @(negedge clk);
            sdone = 1'b0;
        end
        check({2'h0, msel, amode}, 8'h00);
        ext = 1'b0;
    endtask : ext_trigger_burst
    initial begin
        #(8 * 6000);
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(negedge clk);
        rstn = 1'b1;
        key_sequence();
        mode_table();
        watch_to_continuous();
        oneshot_burst();
        ext_trigger_burst();
        report_and_stop();
    end
endmodule : accel_mode_control_tb_top
`default_nettype wire
